// ### common/hbs_pkg.sv
// Package: register map, field positions and constants of the code and HDLC status slice
package hbs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets per framer (index 0 = framer A, index 1 = framer B)
  localparam logic [7:0] RX_HDLC_STATUS_A = 8'h03;
  localparam logic [7:0] RX_CODE_STATUS_A = 8'h04;
  localparam logic [7:0] RX_HDLC_FIFO_A   = 8'h05;
  localparam logic [7:0] TX_HDLC_STATUS_A = 8'h06;
  localparam logic [7:0] RX_HDLC_STATUS_B = 8'ha3;
  localparam logic [7:0] RX_CODE_STATUS_B = 8'ha4;
  localparam logic [7:0] RX_HDLC_FIFO_B   = 8'ha5;
  localparam logic [7:0] TX_HDLC_STATUS_B = 8'ha6;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CODE_SEEN_LATCHED_BIT = 7;
  localparam int CODE_SEEN_LIVE_BIT    = 6;
  localparam int CODE_W                = 6;
  localparam int RX_ABORT_BIT          = 7;
  localparam int RX_CHECKSUM_BIT       = 6;
  localparam int RX_OVERRUN_BIT        = 5;
  localparam int RX_VALID_MSG_BIT      = 4;
  localparam int RX_EMPTY_BIT          = 3;
  localparam int TX_EMPTY_BIT          = 2;
  localparam int TX_FULL_BIT           = 1;
  localparam int TX_UNDERRUN_BIT       = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [5:0] CODE_RESET      = 6'h3f;
  localparam logic [7:0] DATA_W_ZERO     = 8'h00;
  localparam logic [2:0] ABORT_ONES      = 3'h7;
  localparam int         FIFO_DEPTH_DEF  = 16;
  localparam int         NUM_FRAMERS_DEF = 2;

endpackage

// ### rtl/hbs_regs.sv
// Receive code, receive HDLC FIFO and transmit HDLC status registers for two framers

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO, storage in flip-flops, registered full and empty
module hbs_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW-1:0] LAST  = AW'(D - 1);
  localparam logic [AW:0]   FULLC = (AW + 1)'(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic [AW:0]   next_count;
  logic          full_q;
  logic          ready_q;
  logic          empty_q;
  logic          push;
  logic          pop;

  assign push        = in_valid_i & ~full_q;
  assign pop         = out_ready_i & ~empty_q;
  // Kept in its own flop so the ready output leaves the block from a register
  assign in_ready_o  = ready_q;
  assign out_valid_o = ~empty_q;
  assign out_data_o  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW + 1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW + 1)'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count   <= '0;
      full_q  <= 1'b0;
      ready_q <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      count   <= next_count;
      full_q  <= (next_count == FULLC);
      ready_q <= (next_count != FULLC);
      empty_q <= (next_count == '0);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + AW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + AW'(1);
    end
  end

  // Storage has no reset: contents are meaningless until pushed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top: host read port plus per-framer status logic
module hbs_regs
  import hbs_pkg::*;
#(
  parameter int NFR        = NUM_FRAMERS_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     arst_n_i,
  input  wire logic                     host_cs_n_i,
  input  wire logic                     host_rd_n_i,
  input  wire logic [7:0]               host_addr_i,
  output logic      [7:0]               host_data_o,
  output logic                          host_data_oe_o,
  input  wire logic [NFR-1:0]           code_live_i,
  input  wire logic [NFR-1:0]           code_word_valid_i,
  input  wire logic [NFR-1:0][CODE_W-1:0] code_word_i,
  input  wire logic [NFR-1:0]           rx_bit_i,
  input  wire logic [NFR-1:0]           rx_bit_en_i,
  input  wire logic [NFR-1:0]           rx_crc_err_i,
  input  wire logic [NFR-1:0]           rx_msg_ok_i,
  input  wire logic [NFR-1:0]           rx_byte_valid_i,
  input  wire logic [NFR-1:0][7:0]      rx_byte_i,
  output logic      [NFR-1:0]           rx_byte_ready_o,
  input  wire logic [NFR-1:0]           tx_fifo_empty_i,
  input  wire logic [NFR-1:0]           tx_fifo_full_i,
  input  wire logic [NFR-1:0]           tx_underrun_i
);
  localparam logic [7:0] OFS_RXS  [2] = '{RX_HDLC_STATUS_A, RX_HDLC_STATUS_B};
  localparam logic [7:0] OFS_CODE [2] = '{RX_CODE_STATUS_A, RX_CODE_STATUS_B};
  localparam logic [7:0] OFS_FIFO [2] = '{RX_HDLC_FIFO_A, RX_HDLC_FIFO_B};
  localparam logic [7:0] OFS_TXS  [2] = '{TX_HDLC_STATUS_A, TX_HDLC_STATUS_B};

  //////////////////////////////////////////////////////////////////////////////
  // Host pin synchronisers; address must be steady while the read is low
  // Reads spaced by at least one idle cycle are seen as separate reads
  logic [1:0] cs_n_sync;
  logic [1:0] rd_n_sync;
  logic [7:0] addr_s1;
  logic [7:0] addr_s2;
  logic       rd_act_q;
  logic       rd_act;
  logic       rd_start;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_n_sync <= 2'h3;
      rd_n_sync <= 2'h3;
      addr_s1   <= 8'h00;
      addr_s2   <= 8'h00;
    end else begin
      cs_n_sync <= {cs_n_sync[0], host_cs_n_i};
      rd_n_sync <= {rd_n_sync[0], host_rd_n_i};
      addr_s1   <= host_addr_i;
      addr_s2   <= addr_s1;
    end
  end

  assign rd_act   = ~cs_n_sync[1] & ~rd_n_sync[1];
  assign rd_start = rd_act & ~rd_act_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_act_q <= 1'b0;
    end else begin
      rd_act_q <= rd_act;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-framer status, one copy each so framer B is independent of A
  // Unpacked so each framer's read mux is a variable of its own
  logic [7:0] frm_rdata [NFR];
  logic       frm_hit   [NFR];

  for (genvar f = 0; f < NFR; f++) begin : g_frm
    logic              rd_rxs;
    logic              rd_code;
    logic              rd_fifo;
    logic              rd_txs;
    logic              code_live_q;
    logic              code_latched;
    logic [CODE_W-1:0] code_word;
    logic [2:0]        ones_cnt;
    logic              abort_flag;
    logic              crc_flag;
    logic              ovr_flag;
    logic              vm_flag;
    logic              udr_flag;
    logic              abort_set;
    logic              ovr_set;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [7:0]        fifo_out_data;

    assign rd_rxs  = rd_start & (addr_s2 == OFS_RXS[f]);
    assign rd_code = rd_start & (addr_s2 == OFS_CODE[f]);
    assign rd_fifo = rd_start & (addr_s2 == OFS_FIFO[f]);
    assign rd_txs  = rd_start & (addr_s2 == OFS_TXS[f]);

    // A run of ones counts up to the abort threshold and stays there
    assign abort_set = rx_bit_en_i[f] & rx_bit_i[f] & (ones_cnt == ABORT_ONES - 3'h1);
    // A byte offered while full is dropped and reported as overrun
    assign ovr_set   = rx_byte_valid_i[f] & ~fifo_in_ready;

    // Saturating at the threshold keeps a long run from setting abort twice
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ones_cnt <= 3'h0;
      end else if (rx_bit_en_i[f]) begin
        if (!rx_bit_i[f]) begin
          ones_cnt <= 3'h0;
        end else if (ones_cnt != ABORT_ONES) begin
          ones_cnt <= ones_cnt + 3'h1;
        end
      end
    end

    // Set beats the clear-on-read so an event in the read cycle is kept
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        abort_flag <= 1'b0;
        crc_flag   <= 1'b0;
        ovr_flag   <= 1'b0;
        vm_flag    <= 1'b0;
      end else begin
        abort_flag <= abort_set | (abort_flag & ~rd_rxs);
        crc_flag   <= rx_crc_err_i[f] | (crc_flag & ~rd_rxs);
        ovr_flag   <= ovr_set | (ovr_flag & ~rd_rxs);
        vm_flag    <= rx_msg_ok_i[f] | (vm_flag & ~rd_rxs);
      end
    end

    // Underrun arrives as a pulse from the transmit engine; kept until read
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        udr_flag <= 1'b0;
      end else begin
        udr_flag <= tx_underrun_i[f] | (udr_flag & ~rd_txs);
      end
    end

    // Previous live level resets to the idle low, so no false rise after reset
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        code_live_q <= 1'b0;
      end else begin
        code_live_q <= code_live_i[f];
      end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        code_latched <= 1'b0;
      end else begin
        code_latched <= (code_live_i[f] & ~code_live_q) | (code_latched & ~rd_code);
      end
    end

    // Reloading the same code is harmless, so every valid pulse loads
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        code_word <= CODE_RESET;
      end else if (code_word_valid_i[f]) begin
        code_word <= code_word_i[f];
      end
    end

    hbs_fifo #(
      .W (8),
      .D (FIFO_DEPTH)
    ) u_rx_fifo (
      .clk_i       (ref_clk_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (rx_byte_valid_i[f]),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (rx_byte_i[f]),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (rd_fifo),
      .out_data_o  (fifo_out_data)
    );

    assign rx_byte_ready_o[f] = fifo_in_ready;

    always_comb begin
      frm_rdata[f] = DATA_W_ZERO;
      frm_hit[f]   = 1'b1;
      if (addr_s2 == OFS_RXS[f]) begin
        frm_rdata[f][RX_ABORT_BIT]     = abort_flag;
        frm_rdata[f][RX_CHECKSUM_BIT]  = crc_flag;
        frm_rdata[f][RX_OVERRUN_BIT]   = ovr_flag;
        frm_rdata[f][RX_VALID_MSG_BIT] = vm_flag;
        frm_rdata[f][RX_EMPTY_BIT]     = ~fifo_out_valid;
      end else if (addr_s2 == OFS_CODE[f]) begin
        frm_rdata[f][CODE_SEEN_LATCHED_BIT] = code_latched;
        frm_rdata[f][CODE_SEEN_LIVE_BIT]    = code_live_i[f];
        frm_rdata[f][CODE_W-1:0]            = code_word;
      end else if (addr_s2 == OFS_FIFO[f]) begin
        // Empty FIFO reads as zero rather than stale storage
        frm_rdata[f] = fifo_out_valid ? fifo_out_data : DATA_W_ZERO;
      end else if (addr_s2 == OFS_TXS[f]) begin
        // Unassigned upper bits read as zero
        frm_rdata[f][TX_EMPTY_BIT]    = tx_fifo_empty_i[f];
        frm_rdata[f][TX_FULL_BIT]     = tx_fifo_full_i[f];
        frm_rdata[f][TX_UNDERRUN_BIT] = udr_flag;
      end else begin
        frm_hit[f] = 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data is captured once at the start of the read and held steady
  // Offsets of the framers are disjoint, so at most one hit is ever set
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = DATA_W_ZERO;
    for (int i = 0; i < NFR; i++) begin
      if (frm_hit[i]) begin
        next_rdata = frm_rdata[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_data_o <= DATA_W_ZERO;
    end else if (rd_start) begin
      host_data_o <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_data_oe_o <= 1'b0;
    end else begin
      host_data_oe_o <= rd_act;
    end
  end
endmodule

// ### verif/hbs_host.sv
// Host processor model doing read cycles
module hbs_host (
  input  wire logic       clk_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic [7:0]      addr_o,
  input  wire logic [7:0] data_i,
  input  wire logic       oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    addr_o = 8'hff;
  end
  // Pins held until enable is seen; five idle cycles cover the synchroniser
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int n;
    n = 0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    addr_o <= a;
    do begin
      @(posedge clk_i);
      n++;
    end while (oe_i !== 1'b1 && n < 12);
    d = data_i;
    ok = (oe_i === 1'b1);
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    addr_o <= ~a;
    repeat (5) @(posedge clk_i);
  endtask
endmodule

// ### verif/hbs_regs_asserts.sv
// Checker for read-port timing and status fields
module hbs_regs_asserts
  import hbs_pkg::*;
#(
  parameter int NFR        = NUM_FRAMERS_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic           ref_clk_i,
  input wire logic           arst_n_i,
  input wire logic           host_cs_n_i,
  input wire logic           host_rd_n_i,
  input wire logic [7:0]     host_addr_i,
  input wire logic [7:0]     host_data_o,
  input wire logic           host_data_oe_o,
  input wire logic [NFR-1:0] code_live_i,
  input wire logic [NFR-1:0] rx_byte_ready_o,
  input wire logic [NFR-1:0] tx_fifo_empty_i,
  input wire logic [NFR-1:0] tx_fifo_full_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Rise of the enable marks a read; the address was held since the pins fell
  sequence s_rd(a);
    $rose(host_data_oe_o) ##0 $past(host_addr_i, 2) == a;
  endsequence
  property p_oe_cause;
    $rose(host_data_oe_o) |-> $past(!host_cs_n_i && !host_rd_n_i, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("oe without read");
  property p_oe_release;
    $rose(host_rd_n_i) |-> ##[1:4] !host_data_oe_o;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("oe stuck");
  property p_data_hold;
    host_data_oe_o && $past(host_data_oe_o) |-> $stable(host_data_o);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");
  property p_tx_reserved;
    s_rd(TX_HDLC_STATUS_A) |-> host_data_o[7:3] == 5'h00;
  endproperty
  a_tx_reserved: assert property (p_tx_reserved) else $error("tx spare");
  property p_tx_live_a;
    s_rd(TX_HDLC_STATUS_A) |-> host_data_o[2:1] == $past({tx_fifo_empty_i[0], tx_fifo_full_i[0]});
  endproperty
  a_tx_live_a: assert property (p_tx_live_a) else $error("tx a live");
  property p_tx_live_b;
    s_rd(TX_HDLC_STATUS_B) |-> host_data_o[2:1] == $past({tx_fifo_empty_i[1], tx_fifo_full_i[1]});
  endproperty
  a_tx_live_b: assert property (p_tx_live_b) else $error("tx b live");
  property p_code_live;
    s_rd(RX_CODE_STATUS_A) |-> host_data_o[6] == $past(code_live_i[0]);
  endproperty
  a_code_live: assert property (p_code_live) else $error("code live");
  property p_pop_frees;
    s_rd(RX_HDLC_FIFO_A) ##0 $past(!rx_byte_ready_o[0], 2) |-> ##[0:2] rx_byte_ready_o[0];
  endproperty
  a_pop_frees: assert property (p_pop_frees) else $error("no pop");
endmodule
bind hbs_regs hbs_regs_asserts #(.NFR(NFR), .FIFO_DEPTH(FIFO_DEPTH)) u_hbs_regs_asserts (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .host_cs_n_i(host_cs_n_i),
  .host_rd_n_i(host_rd_n_i), .host_addr_i(host_addr_i), .host_data_o(host_data_o),
  .host_data_oe_o(host_data_oe_o), .code_live_i(code_live_i),
  .rx_byte_ready_o(rx_byte_ready_o), .tx_fifo_empty_i(tx_fifo_empty_i),
  .tx_fifo_full_i(tx_fifo_full_i));

// ### verif/hbs_regs_test.sv
// Bench: both framers checked against a queue model
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module hbs_regs_test
  import hbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic            ref_clk, arst_n, cs_n, rd_n, oe;
  logic [7:0]      addr, data;
  logic [1:0]      live, cvalid, rbit, ben, crc, mok, bvalid, rdy, temp, tx_fifo_full_flag, udr;
  logic [1:0][5:0] cword;
  logic [1:0][7:0] byt;
  bit              abt[2], crcf[2], ovr[2], vm[2], code_seen_latched[2], und[2];
  logic [5:0]      code[2] = '{6'h3f, 6'h3f};
  int              run[2], mismatches, num_checks;
  logic [7:0]      q[2][$];
  hbs_regs #(.NFR(2), .FIFO_DEPTH(16)) u_hbs_regs (.ref_clk_i(ref_clk), .arst_n_i(arst_n),
    .host_cs_n_i(cs_n), .host_rd_n_i(rd_n), .host_addr_i(addr), .host_data_o(data),
    .host_data_oe_o(oe), .code_live_i(live), .code_word_valid_i(cvalid), .code_word_i(cword),
    .rx_bit_i(rbit), .rx_bit_en_i(ben), .rx_crc_err_i(crc), .rx_msg_ok_i(mok),
    .rx_byte_valid_i(bvalid), .rx_byte_i(byt), .rx_byte_ready_o(rdy),
    .tx_fifo_empty_i(temp), .tx_fifo_full_i(tx_fifo_full_flag), .tx_underrun_i(udr));
  hbs_host u_hbs_host (.clk_i(ref_clk), .cs_n_o(cs_n), .rd_n_o(rd_n), .addr_o(addr),
    .data_i(data), .oe_i(oe));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic rdc(input int f, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    bit         ok;
    u_hbs_host.rd(a | (f ? 8'ha0 : 8'h00), d, ok);
    if (!ok) begin
      mismatches++;
      end_of_test();
    end
    `CHK($sformatf("reg %h", a), e & m, d & m)
  endtask
  task automatic rdm(input int f, input logic [7:0] a);
    logic [7:0] e;
    case (a)
      RX_HDLC_STATUS_A: e = {abt[f], crcf[f], ovr[f], vm[f], q[f].size() == 0, 3'h0};
      RX_CODE_STATUS_A: e = {code_seen_latched[f], live[f], code[f]};
      RX_HDLC_FIFO_A:   e = (q[f].size() > 0) ? q[f].pop_front() : 8'h00;
      default:          e = {5'h00, temp[f], tx_fifo_full_flag[f], und[f]};
    endcase
    rdc(f, a, (a == TX_HDLC_STATUS_A) ? 8'h07 : 8'hff, e);
    if (a == RX_HDLC_STATUS_A) {abt[f], crcf[f], ovr[f], vm[f]} = 4'h0;
    if (a == RX_CODE_STATUS_A) code_seen_latched[f] = 0;
    if (a == TX_HDLC_STATUS_A) und[f] = 0;
  endtask
  task automatic pulse(input int f, input int k);
    logic [5:0] w;
    w = 6'($urandom);
    @(posedge ref_clk);
    crc[f] <= (k == 0);
    mok[f] <= (k == 1);
    udr[f] <= (k == 2);
    cvalid[f] <= (k == 3);
    cword[f] <= w;
    if (k == 0) crcf[f] = 1;
    if (k == 1) vm[f] = 1;
    if (k == 2) und[f] = 1;
    if (k == 3) code[f] = w;
    @(posedge ref_clk);
    {crc[f], mok[f], udr[f], cvalid[f]} <= 4'h0;
  endtask
  task automatic bits(input int f, input int n, input bit v);
    repeat (n) begin
      @(posedge ref_clk);
      rbit[f] <= v;
      ben[f] <= 1'b1;
      run[f] = v ? run[f] + 1 : 0;
      if (run[f] == 7) abt[f] = 1;
    end
    @(posedge ref_clk);
    ben[f] <= 1'b0;
  endtask
  task automatic push(input int f, input int n);
    logic [7:0] b;
    repeat (n) begin
      b = 8'($urandom);
      @(posedge ref_clk);
      bvalid[f] <= 1'b1;
      byt[f] <= b;
      if (q[f].size() < 16) q[f].push_back(b);
      else ovr[f] = 1;
    end
    @(posedge ref_clk);
    bvalid[f] <= 1'b0;
  endtask
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    void'($urandom(32'h587df651));
    {live, cvalid, rbit, ben, crc, mok, bvalid, temp, tx_fifo_full_flag, udr} = 20'h0;
    cword = '0;
    byt = '0;
    arst_n = 0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1;
    for (int f = 0; f < 2; f++) begin
      for (int a = 3; a < 7; a++) rdm(f, 8'(a));
    end
    rdc(0, 8'h00, 8'hff, 8'h00);
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 4; k++) pulse(f, k);
      @(posedge ref_clk);
      live[f] <= 1'b1;
      code_seen_latched[f] = 1;
      bits(f, 6, 1);
      bits(f, 1, 0);
      rdm(f, RX_HDLC_STATUS_A);
      bits(f, 7, 1);
      repeat (2) for (int a = 3; a < 7; a++) rdm(f, 8'(a));
      live[f] <= 1'b0;
      @(posedge ref_clk);
      rdm(f, RX_CODE_STATUS_A);
    end
    push(0, 17);
    push(1, 3);
    `CHK("ready", 1'b0, rdy[0])
    rdm(0, RX_HDLC_STATUS_A);
    repeat (18) rdm(0, RX_HDLC_FIFO_A);
    `CHK("ready", 1'b1, rdy[0])
    rdm(0, RX_HDLC_STATUS_A);
    repeat (4) rdm(1, RX_HDLC_FIFO_A);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      temp <= 2'(i);
      tx_fifo_full_flag <= ~2'(i);
      @(posedge ref_clk);
      rdm(0, TX_HDLC_STATUS_A);
      rdm(1, TX_HDLC_STATUS_A);
    end
    end_of_test();
  end
endmodule
